// >>> gpm_pkg.sv
// Purpose: Constants for the shared pin function multiplexer
// Assumes: 100 MHz system clock
// Notes:   Pin setting byte layout and designation codes
package gpm_pkg;
  localparam int unsigned NUM_PINS      = 4;
  localparam int unsigned DES_LSB       = 0;
  localparam int unsigned DES_MSB       = 2;
  localparam int unsigned DIR_BIT       = 3;
  localparam int unsigned OUTVAL_BIT    = 4;
  localparam logic [2:0]  DES_GPIO      = 3'h0;
  localparam logic [2:0]  DES_DEDICATED = 3'h1;
  localparam logic [2:0]  DES_ALT0      = 3'h2;
  localparam logic [2:0]  DES_ALT1      = 3'h3;
  localparam logic [2:0]  DES_ALT2      = 3'h4;
  localparam logic [7:0]  SETTING_RESET = 8'h00;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned LAMP_MS       = 4;
  localparam int unsigned LAMP_CYCLES   = CLK_HZ / 1000 * LAMP_MS;
  localparam int unsigned RST_FILT_NS   = 1000;
  localparam int unsigned RST_FILT_CYC  = (RST_FILT_NS + 9) / 10;
  localparam int unsigned CLKDIV_W      = 16;
  localparam logic [15:0] CLKDIV_RESET  = 16'h0004;
endpackage

// >>> gpm_lamp.sv
// Purpose: Activity lamp, idles high, pulses low after traffic
// Assumes: Traffic is a one-cycle pulse
// Notes:   Pulse length is a parameter for simulation
`timescale 1ns/1ps
`default_nettype none
module gpm_lamp #(
  parameter int unsigned CYCLES = gpm_pkg::LAMP_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_traffic,
  output logic      o_lamp
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_lamp;

  always_comb
  begin
    next_count = count;
    if (i_traffic)
      next_count = CYCLES;
    else if (count != 32'h0)
      next_count = count - 32'h1;
    next_lamp = (next_count == 32'h0);
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      count  <= 32'h0;
      o_lamp <= 1'b1;
    end
    else
    begin
      count  <= next_count;
      o_lamp <= next_lamp;
    end
  end

  a_lamp_restart: assert property (@(posedge i_clk) disable iff (i_reset)
    i_traffic |=> !o_lamp) else $error("lamp not low after traffic");
endmodule
`default_nettype wire

// >>> gpm_pin_mux.sv
// Purpose: Function multiplexer for four shared general-purpose pins
// Assumes: Inputs synchronous to i_clk; settings bytes held stable by software
// Notes:   Analog paths are reported as select strobes; converters live elsewhere
// Operation
// - Only the edge detector requests wake-up
// - Armed detector edge during suspend wakes host
// - Plain mode drives commanded level, returns samples
// - Suspend indicator low in suspend, high after
// - Configured indicator low until configured
// - Configured indicator low while suspended
// - Activity lamps idle high, pulse low
// - Three-bit code selects each pin's function
// - Dedicated code maps indicator, clock, indicator, lamp
// - Pins 1 to 3 feed converter channels
// - Pins 2,3 share one output converter
// - Pin 1 clock output, divider adjustable
// - Detector flags selected edges on pin 1
// - Reset held by filtered low reset pin
// - Power-on reset initialises everything
// - Setting byte: code, direction, default value
`timescale 1ns/1ps
`default_nettype none
module gpm_pin_mux #(
  parameter int unsigned LAMP_CYCLES = gpm_pkg::LAMP_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_reset_pin_n,
  input  wire logic [7:0]  i_setting_0,
  input  wire logic [7:0]  i_setting_1,
  input  wire logic [7:0]  i_setting_2,
  input  wire logic [7:0]  i_setting_3,
  input  wire logic        i_out_write,
  input  wire logic [3:0]  i_out_value,
  input  wire logic [1:0]  i_edge_select,
  input  wire logic        i_detector_clear,
  input  wire logic        i_remote_wake_enable,
  input  wire logic [15:0] i_clk_divide,
  input  wire logic        i_usb_suspended,
  input  wire logic        i_usb_configured,
  input  wire logic        i_uart_rx_traffic,
  input  wire logic        i_uart_tx_traffic,
  input  wire logic        i_i2c_traffic,
  input  wire logic [3:0]  i_pin_in,
  output logic      [3:0]  o_pin_out,
  output logic      [3:0]  o_pin_oe,
  output logic      [3:0]  o_pin_level,
  output logic             o_detector_flag,
  output logic             o_remote_wake,
  output logic      [3:1]  o_adc_select,
  output logic      [3:2]  o_dac_select,
  output logic             o_reset_n
);
  logic [7:0] setting [gpm_pkg::NUM_PINS];

  function automatic logic [2:0] des_of(input logic [7:0] s);
    des_of = s[gpm_pkg::DES_MSB:gpm_pkg::DES_LSB];
  endfunction

  always_comb
  begin
    setting[0] = i_setting_0;
    setting[1] = i_setting_1;
    setting[2] = i_setting_2;
    setting[3] = i_setting_3;
  end

  // Reset pin filter: low must persist before reset asserts
  logic [7:0] filt_count;
  logic [7:0] next_filt_count;
  logic       next_reset_n;

  always_comb
  begin
    next_filt_count = filt_count;
    next_reset_n    = o_reset_n;
    if (i_reset_pin_n)
    begin
      next_filt_count = 8'h00;
      next_reset_n    = 1'b1;
    end
    else if (filt_count == 8'(gpm_pkg::RST_FILT_CYC))
      next_reset_n = 1'b0;
    else
      next_filt_count = filt_count + 8'h01;
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      filt_count <= 8'h00;
      o_reset_n  <= 1'b0;
    end
    else
    begin
      filt_count <= next_filt_count;
      o_reset_n  <= next_reset_n;
    end
  end

  // Internal reset combines power-on and filtered pin reset
  logic core_reset;
  assign core_reset = i_reset || !o_reset_n;

  // Plain output latch, loaded from default bits after reset
  logic [3:0] gpio_q;
  logic [3:0] next_gpio_q;
  logic       loaded;

  always_comb
  begin
    next_gpio_q = gpio_q;
    if (!loaded)
      for (int i = 0; i < 4; i++)
        next_gpio_q[i] = setting[i][gpm_pkg::OUTVAL_BIT];
    else if (i_out_write)
      next_gpio_q = i_out_value;
  end

  always_ff @(posedge i_clk or posedge core_reset)
  begin
    if (core_reset)
    begin
      gpio_q <= 4'h0;
      loaded <= 1'b0;
    end
    else
    begin
      gpio_q <= next_gpio_q;
      loaded <= 1'b1;
    end
  end

  // Clock output divider: toggles every i_clk_divide + 1 cycles
  logic [15:0] div_count;
  logic [15:0] next_div_count;
  logic        ref_clk;
  logic        next_ref_clk;

  always_comb
  begin
    next_div_count = div_count + 16'h0001;
    next_ref_clk   = ref_clk;
    if (div_count >= i_clk_divide)
    begin
      next_div_count = 16'h0000;
      next_ref_clk   = !ref_clk;
    end
  end

  always_ff @(posedge i_clk or posedge core_reset)
  begin
    if (core_reset)
    begin
      div_count <= 16'h0000;
      ref_clk   <= 1'b0;
    end
    else
    begin
      div_count <= next_div_count;
      ref_clk   <= next_ref_clk;
    end
  end

  // Edge detector on shared pin 1
  logic det_mode;
  logic prev_pin1;
  logic next_prev_pin1;
  logic next_flag;
  logic next_wake;
  logic edge_hit;

  assign det_mode = (des_of(setting[1]) == gpm_pkg::DES_ALT2);

  always_comb
  begin
    next_prev_pin1 = i_pin_in[1];
    edge_hit = det_mode && loaded && ( // No history yet in the first cycle out of reset
      (i_edge_select[0] && i_pin_in[1] && !prev_pin1) ||
      (i_edge_select[1] && !i_pin_in[1] && prev_pin1));
    next_flag = o_detector_flag;
    if (i_detector_clear)
      next_flag = 1'b0;
    if (edge_hit)
      next_flag = 1'b1; // Set wins over clear
    // Only the detector may wake; the wake enable must be high in the cycle the edge is seen
    next_wake = edge_hit && i_usb_suspended && i_remote_wake_enable;
  end

  always_ff @(posedge i_clk or posedge core_reset)
  begin
    if (core_reset)
    begin
      prev_pin1       <= 1'b0;
      o_detector_flag <= 1'b0;
      o_remote_wake   <= 1'b0;
    end
    else
    begin
      prev_pin1       <= next_prev_pin1;
      o_detector_flag <= next_flag;
      o_remote_wake   <= next_wake;
    end
  end

  // Activity lamps
  logic lamp_rx;
  logic lamp_tx;
  logic lamp_i2c;

  gpm_lamp #(.CYCLES(LAMP_CYCLES)) u_lamp_rx (
    .i_clk     (i_clk),
    .i_reset   (core_reset),
    .i_traffic (i_uart_rx_traffic),
    .o_lamp    (lamp_rx)
  );
  gpm_lamp #(.CYCLES(LAMP_CYCLES)) u_lamp_tx (
    .i_clk     (i_clk),
    .i_reset   (core_reset),
    .i_traffic (i_uart_tx_traffic),
    .o_lamp    (lamp_tx)
  );
  gpm_lamp #(.CYCLES(LAMP_CYCLES)) u_lamp_i2c (
    .i_clk     (i_clk),
    .i_reset   (core_reset),
    .i_traffic (i_i2c_traffic),
    .o_lamp    (lamp_i2c)
  );

  // Indicators
  logic suspend_ind;
  logic config_ind;
  assign suspend_ind = !i_usb_suspended;
  assign config_ind  = i_usb_configured && !i_usb_suspended;

  // Per-pin function selection
  logic [3:0] next_out;
  logic [3:0] next_oe;
  logic [3:1] next_adc;
  logic [3:2] next_dac;

  always_comb
  begin
    next_out = 4'h0;
    next_oe  = 4'h0;
    next_adc = 3'h0;
    next_dac = 2'h0;
    for (int p = 0; p < 4; p++)
    begin
      unique case (des_of(setting[p]))
        gpm_pkg::DES_GPIO:
        begin
          next_oe[p]  = !setting[p][gpm_pkg::DIR_BIT];
          next_out[p] = gpio_q[p];
        end
        gpm_pkg::DES_DEDICATED:
        begin
          next_oe[p] = 1'b1;
          case (p)
            0: next_out[p] = suspend_ind;
            1: next_out[p] = ref_clk;
            2: next_out[p] = config_ind;
            default: next_out[p] = lamp_i2c;
          endcase
        end
        gpm_pkg::DES_ALT0:
        begin
          if (p == 0)
          begin
            next_oe[p]  = 1'b1;
            next_out[p] = lamp_rx;
          end
          else
            next_adc[p] = 1'b1;
        end
        gpm_pkg::DES_ALT1:
        begin
          if (p == 1)
          begin
            next_oe[p]  = 1'b1;
            next_out[p] = lamp_tx;
          end
          else if (p >= 2)
            next_dac[p] = 1'b1;
        end
        default:
        begin
          next_oe[p] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge core_reset)
  begin
    if (core_reset)
    begin
      o_pin_out    <= 4'h0;
      o_pin_oe     <= 4'h0;
      o_pin_level  <= 4'h0;
      o_adc_select <= 3'h0;
      o_dac_select <= 2'h0;
    end
    else
    begin
      o_pin_out    <= next_out;
      o_pin_oe     <= next_oe;
      o_pin_level  <= i_pin_in;
      o_adc_select <= next_adc;
      o_dac_select <= next_dac;
    end
  end

  a_wake_only_det: assert property (@(posedge i_clk) disable iff (core_reset)
    o_remote_wake |-> $past(det_mode) && o_detector_flag) else $error("wake without edge");
  a_rise_sets_flag: assert property (@(posedge i_clk) disable iff (core_reset)
    loaded && det_mode && i_edge_select[0] && i_pin_in[1] && !prev_pin1 |=> o_detector_flag)
    else $error("rising edge missed");
  a_wake_on_edge: assert property (@(posedge i_clk) disable iff (core_reset)
    det_mode && i_edge_select[1] && prev_pin1 && !i_pin_in[1] && i_usb_suspended
    && i_remote_wake_enable |=> o_remote_wake && o_detector_flag) else $error("no wake");
  a_suspend_ind: assert property (@(posedge i_clk) disable iff (core_reset)
    des_of(setting[0]) == gpm_pkg::DES_DEDICATED && i_usb_suspended |=> !o_pin_out[0])
    else $error("suspend indicator high");
  a_cfg_suspend: assert property (@(posedge i_clk) disable iff (core_reset)
    des_of(setting[2]) == gpm_pkg::DES_DEDICATED && i_usb_suspended |=> !o_pin_out[2])
    else $error("configured indicator high in suspend");
  a_reserved_idle: assert property (@(posedge i_clk) disable iff (core_reset)
    des_of(setting[0]) >= gpm_pkg::DES_ALT1 |=> !o_pin_oe[0])
    else $error("reserved code drives pin");
  a_dac_shared: assert property (@(posedge i_clk) disable iff (core_reset)
    des_of(setting[3]) == gpm_pkg::DES_ALT1 |=> o_dac_select[3] && !o_pin_oe[3])
    else $error("dac route wrong");
  a_gpio_drive: assert property (@(posedge i_clk) disable iff (core_reset)
    loaded && des_of(setting[2]) == gpm_pkg::DES_GPIO && !setting[2][gpm_pkg::DIR_BIT]
    |=> o_pin_oe[2] && o_pin_out[2] == $past(gpio_q[2])) else $error("gpio drive");
endmodule
`default_nettype wire

// >>> gpm_pin_model.sv
// Purpose: Application circuitry sitting on the four shared pins
// Assumes: The external driver yields to the block wherever the block drives
// Notes:   No pull resistors, so the bench gives every undriven pin a level
`timescale 1ns/1ps
`default_nettype none
module gpm_pin_model (
  input  wire logic [3:0] i_pin_out,
  input  wire logic [3:0] i_pin_oe,
  input  wire logic [3:0] i_ext,
  output logic      [3:0] o_pin
);
  // The wire level: the block's value where it drives, the outside level elsewhere
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      o_pin[i] = i_pin_oe[i] ? i_pin_out[i] : i_ext[i];
    end
  end
endmodule
`default_nettype wire

// >>> gp_pin_function_mux_tb.sv
// Purpose: Self-checking bench for the shared pin multiplexer
// Assumes: Lamp pulse shortened to 20 cycles
// Notes:   Inputs change on the falling edge, outputs are read there too
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module gp_pin_function_mux_tb;
  typedef struct packed {
    logic [31:0] s;
    logic        sp;
    logic        cf;
    logic [3:0]  m;
    logic [3:0]  oe;
    logic [3:0]  out;
    logic [2:0]  adc;
    logic [1:0]  dac;
  } gpm_row_t;
  logic i_clk = 0, i_reset = 1, rp_n = 1, wr = 0, clr = 0, wen = 0, susp = 0, cfg = 0;
  logic rx = 0, tx = 0, i2c = 0, a;
  logic [7:0]  s0 = 8'h10, s1 = 8'h10, s2 = 8'h10, s3 = 8'h10;
  logic [3:0]  val = 4'h0, ext = 4'h0, pin, p_out, p_oe, p_lvl;
  logic [1:0]  esel = 2'h0, dac;
  logic [2:0]  adc;
  logic [15:0] div = 16'h0003;
  logic        flag, wake, rst_n;
  int bad_count = 0, checks_done = 0, wake_count = 0, cyc = 0, w;
  gpm_row_t rows [6] = '{
    '{32'h01010101, 1'b0, 1'b1, 4'hD, 4'hD, 4'hD, 3'h0, 2'h0},
    '{32'h01010101, 1'b1, 1'b1, 4'hD, 4'hD, 4'h8, 3'h0, 2'h0},
    '{32'h01010101, 1'b0, 1'b0, 4'hD, 4'hD, 4'h9, 3'h0, 2'h0},
    '{32'h02020202, 1'b0, 1'b1, 4'hF, 4'h1, 4'h1, 3'h7, 2'h0},
    '{32'h03030303, 1'b0, 1'b1, 4'h3, 4'h2, 4'h2, 3'h0, 2'h3},
    '{32'h07060405, 1'b0, 1'b1, 4'hF, 4'h0, 4'h0, 3'h0, 2'h0}};
  gpm_pin_mux #(.LAMP_CYCLES(20)) u_gpm_pin_mux (
    .i_clk(i_clk), .i_reset(i_reset), .i_reset_pin_n(rp_n),
    .i_setting_0(s0), .i_setting_1(s1), .i_setting_2(s2), .i_setting_3(s3),
    .i_out_write(wr), .i_out_value(val), .i_edge_select(esel),
    .i_detector_clear(clr), .i_remote_wake_enable(wen), .i_clk_divide(div),
    .i_usb_suspended(susp), .i_usb_configured(cfg), .i_uart_rx_traffic(rx),
    .i_uart_tx_traffic(tx), .i_i2c_traffic(i2c), .i_pin_in(pin),
    .o_pin_out(p_out), .o_pin_oe(p_oe), .o_pin_level(p_lvl),
    .o_detector_flag(flag), .o_remote_wake(wake), .o_adc_select(adc),
    .o_dac_select(dac), .o_reset_n(rst_n));
  gpm_pin_model u_gpm_pin_model (
    .i_pin_out(p_out), .i_pin_oe(p_oe), .i_ext(ext), .o_pin(pin));
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  // Wake pulses are one cycle long, so they are counted rather than sampled
  always @(posedge i_clk)
  begin
    cyc++;
    if (wake === 1'b1) wake_count++;
    if (cyc == 5000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    tick(1);
    `CHK(rst_n, 1'b0)
    `CHK(p_oe, 4'h0)
    tick(1);
    i_reset = 0;
    tick(3);
    `CHK(rst_n, 1'b1)
    `CHK(p_oe, 4'hF)
    `CHK(p_out, 4'hF)
    wr = 1;
    val = 4'hA;
    tick(1);
    wr = 0;
    tick(2);
    `CHK(p_out, 4'hA)
    s3 = 8'h18;
    ext = 4'h8;
    tick(3);
    `CHK(p_oe, 4'h7)
    `CHK(p_lvl[3], 1'b1)
    ext = 4'h0;
    tick(3);
    `CHK(p_lvl[3], 1'b0)
    $display("gpio test done");
    foreach (rows[i])
    begin
      {s3, s2, s1, s0} = rows[i].s;
      susp = rows[i].sp;
      cfg = rows[i].cf;
      tick(3);
      `CHK(p_oe & rows[i].m, rows[i].oe)
      `CHK(p_out & rows[i].oe & 4'hD, rows[i].out & 4'hD)
      `CHK(adc, rows[i].adc)
      `CHK(dac, rows[i].dac)
    end
    $display("table test done");
    {s3, s2, s1, s0} = 32'h01010101;
    tick(6);
    a = p_out[1];
    tick(4);
    `CHK(p_out[1], ~a)
    tick(4);
    `CHK(p_out[1], a)
    div = 16'h0001;
    tick(4);
    a = p_out[1];
    tick(2);
    `CHK(p_out[1], ~a)
    tick(2);
    `CHK(p_out[1], a)
    $display("clock test done");
    {s3, s2, s1, s0} = 32'h01000302;
    susp = 1;
    wen = 1;
    tick(3);
    w = wake_count;
    {rx, tx, i2c} = 3'h7;
    tick(1);
    {rx, tx, i2c} = 3'h0;
    tick(9);
    `CHK(p_out & 4'hB, 4'h0)
    {rx, tx, i2c} = 3'h7;
    tick(1);
    {rx, tx, i2c} = 3'h0;
    tick(14);
    `CHK(p_out & 4'hB, 4'h0)
    tick(12);
    `CHK(p_out & 4'hB, 4'hB)
    `CHK(wake_count, w)
    $display("lamp test done");
    {s3, s2, s1, s0} = 32'h00000400;
    for (int e = 1; e < 4; e++)
    begin
      esel = 2'(e);
      tick(3);
      clr = 1;
      tick(1);
      clr = 0;
      w = wake_count;
      ext[1] = 1;
      tick(4);
      `CHK(flag, e[0])
      `CHK(wake_count - w, int'(e[0]))
      clr = 1;
      tick(1);
      clr = 0;
      ext[1] = 0;
      tick(4);
      `CHK(flag, e[1])
    end
    $display("detector test done");
    rp_n = 0;
    tick(10);
    rp_n = 1;
    tick(2);
    `CHK(rst_n, 1'b1)
    rp_n = 0;
    tick(120);
    `CHK(rst_n, 1'b0)
    `CHK(p_oe, 4'h0)
    ext[1] = 1;
    w = wake_count;
    rp_n = 1;
    tick(5);
    `CHK(rst_n, 1'b1)
    `CHK(flag, 1'b0)
    `CHK(wake_count, w)
    $display("reset pin test done");
    complete_run();
  end
endmodule
`default_nettype wire
